// ---- verilog/converter_strap_override_defines.svh ----
// Purpose: offsets, field positions, reset values and timing for the strap override registers
// Assumes: 10 MHz core clock
// Notes: included by the package and the register module
`ifndef CONVERTER_STRAP_OVERRIDE_DEFINES_SVH
`define CONVERTER_STRAP_OVERRIDE_DEFINES_SVH

// ----------------------------------------
// register offsets (command codes)
// ----------------------------------------
`define OFF_DELAY_CONFIG 8'hD1
`define OFF_STRAP_OVERRIDE 8'hD2
`define OFF_LOOP_FREQUENCY 8'hD3

// ----------------------------------------
// field positions
// ----------------------------------------
`define DLY_CODE_MSB 2
`define DLY_CODE_LSB 0
`define BIT_EXT_REF 7
`define BIT_EXT_RAMP 6
`define BIT_SKIP_FORCE 4
`define SS_TIME_MSB 3
`define SS_TIME_LSB 2
`define BIT_UV_LATCH 1
`define BIT_CCM 0
`define BIT_RAMP_INJ 7
`define RSCALE_MSB 5
`define RSCALE_LSB 4
`define FREQ_MSB 2
`define FREQ_LSB 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define DLY_CODE_RESET 3'h2
`define SKIP_FORCE_RESET 1'b1
`define FREQ_RESET 3'h3

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_MHZ 10
`define DLY_BASE_US 256
`define SS_BASE_US 1000
`define CYC_W 20
`define KHZ_W 11
`define STRAP_SETTLE 2'h2

`endif

// ---- verilog/converter_strap_override_pkg.sv ----
// Purpose: types for the strap override register block
// Assumes: defines header present
// Notes: state of the register module is one packed struct
package converter_strap_override_pkg;
`include "converter_strap_override_defines.svh"

  typedef struct packed {
    logic [8:0] strapMeta;
    logic [8:0] strapSync;
    logic [1:0] settleCnt;
    logic strapLoaded;
    logic [2:0] powerOnDelayCode;
    logic externalReferenceSelect;
    logic externalRampSelect;
    logic softstartSkipForce;
    logic [1:0] softstartTimeCode;
    logic undervoltageLatchSelect;
    logic conductionModeSelect;
    logic rampInjectionEnable;
    logic [1:0] rampResistorScale;
    logic [2:0] switchingFrequencyCode;
    logic [7:0] rdData;
    logic [`CYC_W-1:0] delayCycles;
    logic [`CYC_W-1:0] ssCycles;
    logic [`KHZ_W-1:0] freqKhz;
    logic skipNow;
  } regs_state_t;

endpackage : converter_strap_override_pkg

// ---- verilog/converter_strap_override_regs.sv ----
// Purpose: strap-loaded configuration registers of a buck converter controller
// Assumes: command codes arrive from a management bus decoder on core_clk
// Notes: strap pins are static after power-up and are double synchronised;
//   a strap load wins over a host write in the same cycle, once per reset;
//   decoded counts and kHz lag their field by one clock
`timescale 1ns/1ps
`include "converter_strap_override_defines.svh"

// Contract
// - the power-on delay code decodes as doubling steps from 256 us to 32.768 ms.
// - the power-on delay code sits in bits 2:0 of the delay register, writable, reset 010b.
// - strap-derived fields load from the sampled straps, read back, and stay writable.
// - host overrides of strap fields last only until the next power-on reset.
// - bit 7 of the strap register selects internal (0) or external tracking reference (1).
// - bit 6 of the strap register selects internal ramp (0) or external sequencing (1).
// - bits 3:2 select a soft-start time of 1, 2, 4 or 8 ms.
// - bit 1 selects hiccup (0) or latch-off (1) after undervoltage and is driven out.
// - bit 0 selects skip mode (0) or forced continuous conduction (1); with bit 4 set, skip mode holds during soft start.
// - bit 7 of the loop register enables ramp injection, strap-loaded and writable.
// - bits 5:4 of the loop register scale the ramp resistor by 1/2, 1, 2 or 3.
// - bits 2:0 of the loop register select the switching frequency, reset 011b.
module converter_strap_override_regs #(
  parameter int DELAY_BASE_CYCLES = `DLY_BASE_US * `CLK_MHZ,
  parameter int SOFTSTART_BASE_CYCLES = `SS_BASE_US * `CLK_MHZ
) (
  // clock and power-on reset
  input wire logic core_clk,
  input wire logic rst,
  // command-code register port
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  // pin straps, asynchronous to core_clk
  input wire logic strapExtRef,
  input wire logic strapExtRamp,
  input wire logic [1:0] strapSoftstartTime,
  input wire logic strapUvLatch,
  input wire logic strapCcm,
  input wire logic strapRampInj,
  input wire logic [1:0] strapRampScale,
  // soft-start status, same clock domain
  input wire logic softstartActive,
  // field outputs and decoded settings
  output logic strapLoaded,
  output logic [2:0] power_on_delay_code,
  output logic [`CYC_W-1:0] powerOnDelayCycles,
  output logic external_reference_select,
  output logic external_ramp_select,
  output logic [`CYC_W-1:0] softstartCycles,
  output logic undervoltage_latch_select,
  output logic forced_continuous_conduction,
  output logic ramp_injection_enable,
  output logic [1:0] ramp_resistor_scale,
  output logic [2:0] switching_frequency_code,
  output logic [`KHZ_W-1:0] switchingFrequencyKhz
);
  import converter_strap_override_pkg::*;

  regs_state_t state_ff;
  regs_state_t nxt_state;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // base count doubled per code step; the base is cut to the counter width on purpose
  function automatic logic [`CYC_W-1:0] doubling(input int base, input logic [2:0] code);
    doubling = `CYC_W'(base) << code;
  endfunction : doubling

  // frequency code to kHz
  function automatic logic [`KHZ_W-1:0] freq_khz(input logic [2:0] code);
    case (code)
      3'h0: freq_khz = 11'h13B; // 315 kHz
      3'h1: freq_khz = 11'h1A9; // 425 kHz
      3'h2: freq_khz = 11'h226; // 550 kHz
      3'h3: freq_khz = 11'h28A; // 650 kHz
      3'h4: freq_khz = 11'h339; // 825 kHz
      3'h5: freq_khz = 11'h384; // 900 kHz
      3'h6: freq_khz = 11'h401; // 1025 kHz
      default: freq_khz = 11'h465; // 1125 kHz
    endcase
  endfunction : freq_khz

  // ----------------------------------------
  // next state
  // ----------------------------------------
  // strap sampling, host writes, readback and decoding
  always_comb begin
    nxt_state = state_ff;

    // ----------------------------------------
    // strap synchroniser
    // ----------------------------------------
    // two flops per strap pin; only the second stage feeds the load below
    nxt_state.strapMeta = {strapExtRef,
                           strapExtRamp,
                           strapSoftstartTime,
                           strapUvLatch,
                           strapCcm,
                           strapRampInj,
                           strapRampScale};
    nxt_state.strapSync = state_ff.strapMeta;

    // ----------------------------------------
    // host writes
    // ----------------------------------------
    // masked per field so reserved bits stay zero
    if (regWrEn) begin
      if (regAddr == `OFF_DELAY_CONFIG) begin
        nxt_state.powerOnDelayCode = regWrData[`DLY_CODE_MSB:`DLY_CODE_LSB];
      end else if (regAddr == `OFF_STRAP_OVERRIDE) begin
        nxt_state.externalReferenceSelect = regWrData[`BIT_EXT_REF];
        nxt_state.externalRampSelect = regWrData[`BIT_EXT_RAMP];
        nxt_state.softstartSkipForce = regWrData[`BIT_SKIP_FORCE];
        nxt_state.softstartTimeCode = regWrData[`SS_TIME_MSB:`SS_TIME_LSB];
        nxt_state.undervoltageLatchSelect = regWrData[`BIT_UV_LATCH];
        nxt_state.conductionModeSelect = regWrData[`BIT_CCM];
      end else if (regAddr == `OFF_LOOP_FREQUENCY) begin
        nxt_state.rampInjectionEnable = regWrData[`BIT_RAMP_INJ];
        nxt_state.rampResistorScale = regWrData[`RSCALE_MSB:`RSCALE_LSB];
        nxt_state.switchingFrequencyCode = regWrData[`FREQ_MSB:`FREQ_LSB];
      end
    end

    // ----------------------------------------
    // one-time strap load
    // ----------------------------------------
    // waits for the synchroniser to fill; wins over a host write in the same cycle
    if (!state_ff.strapLoaded) begin
      if (state_ff.settleCnt == `STRAP_SETTLE) begin
        {nxt_state.externalReferenceSelect,
         nxt_state.externalRampSelect,
         nxt_state.softstartTimeCode,
         nxt_state.undervoltageLatchSelect,
         nxt_state.conductionModeSelect,
         nxt_state.rampInjectionEnable,
         nxt_state.rampResistorScale} = state_ff.strapSync;
        nxt_state.strapLoaded = 1'b1;
      end else begin
        nxt_state.settleCnt = state_ff.settleCnt + 2'h1;
      end
    end

    // ----------------------------------------
    // readback
    // ----------------------------------------
    // one-cycle read word; reserved bits and unmapped codes read zero
    nxt_state.rdData = 8'h00;
    if (regRdEn) begin
      if (regAddr == `OFF_DELAY_CONFIG) begin
        nxt_state.rdData[`DLY_CODE_MSB:`DLY_CODE_LSB] = state_ff.powerOnDelayCode;
      end else if (regAddr == `OFF_STRAP_OVERRIDE) begin
        nxt_state.rdData[`BIT_EXT_REF] = state_ff.externalReferenceSelect;
        nxt_state.rdData[`BIT_EXT_RAMP] = state_ff.externalRampSelect;
        nxt_state.rdData[`BIT_SKIP_FORCE] = state_ff.softstartSkipForce;
        nxt_state.rdData[`SS_TIME_MSB:`SS_TIME_LSB] = state_ff.softstartTimeCode;
        nxt_state.rdData[`BIT_UV_LATCH] = state_ff.undervoltageLatchSelect;
        nxt_state.rdData[`BIT_CCM] = state_ff.conductionModeSelect;
      end else if (regAddr == `OFF_LOOP_FREQUENCY) begin
        nxt_state.rdData[`BIT_RAMP_INJ] = state_ff.rampInjectionEnable;
        nxt_state.rdData[`RSCALE_MSB:`RSCALE_LSB] = state_ff.rampResistorScale;
        nxt_state.rdData[`FREQ_MSB:`FREQ_LSB] = state_ff.switchingFrequencyCode;
      end
    end

    // ----------------------------------------
    // decoded settings
    // ----------------------------------------
    // counts and kHz follow the fields one clock later
    nxt_state.delayCycles = doubling(DELAY_BASE_CYCLES, state_ff.powerOnDelayCode);
    nxt_state.ssCycles = doubling(SOFTSTART_BASE_CYCLES,
                                  {1'b0, state_ff.softstartTimeCode});
    nxt_state.freqKhz = freq_khz(state_ff.switchingFrequencyCode);
    // skip while forced during soft start, else as the conduction mode bit says
    nxt_state.skipNow = (state_ff.softstartSkipForce && softstartActive) ||
                        !state_ff.conductionModeSelect;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  // power-on reset clears every override; the straps reload once it is released
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff <= '0;
      state_ff.powerOnDelayCode <= `DLY_CODE_RESET;
      state_ff.softstartSkipForce <= `SKIP_FORCE_RESET;
      state_ff.switchingFrequencyCode <= `FREQ_RESET;
      state_ff.skipNow <= 1'b1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // register port and strap status
  assign regRdData = state_ff.rdData;
  assign strapLoaded = state_ff.strapLoaded;

  // delay register
  assign power_on_delay_code = state_ff.powerOnDelayCode;
  assign powerOnDelayCycles = state_ff.delayCycles;

  // strap override register; conduction mode leaves through the skip gate
  assign external_reference_select = state_ff.externalReferenceSelect;
  assign external_ramp_select = state_ff.externalRampSelect;
  assign softstartCycles = state_ff.ssCycles;
  assign undervoltage_latch_select = state_ff.undervoltageLatchSelect;
  assign forced_continuous_conduction = !state_ff.skipNow;

  // loop and frequency register
  assign ramp_injection_enable = state_ff.rampInjectionEnable;
  assign ramp_resistor_scale = state_ff.rampResistorScale;
  assign switching_frequency_code = state_ff.switchingFrequencyCode;
  assign switchingFrequencyKhz = state_ff.freqKhz;

endmodule : converter_strap_override_regs

// ---- tb/converter_strap_override_sva.sv ----
// Purpose: concurrent checks on the strap override register ports
// Assumes: DELAY_BASE_CYCLES matches the bound instance
// Notes: bind statement sits after the module
`timescale 1ns/1ps
module converter_strap_override_sva #(
  parameter int DELAY_BASE_CYCLES = 4
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  input wire logic [7:0] regRdData,
  input wire logic strapExtRef,
  input wire logic strapRampInj,
  input wire logic strapLoaded,
  input wire logic [2:0] power_on_delay_code,
  input wire logic [19:0] powerOnDelayCycles,
  input wire logic external_reference_select,
  input wire logic ramp_injection_enable,
  input wire logic [2:0] switching_frequency_code,
  input wire logic [10:0] switchingFrequencyKhz
);
  localparam logic [10:0] KHZ [8] = '{11'h13B, 11'h1A9, 11'h226, 11'h28A,
    11'h339, 11'h384, 11'h401, 11'h465};
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // straps land a few edges after release; a write once loaded
  sequence loadSeq;
    !strapLoaded ##[1:3] strapLoaded;
  endsequence
  sequence wrTo(a);
    regWrEn && regAddr == a && strapLoaded;
  endsequence
  a_load_time: assert property ($fell(rst) |-> loadSeq)
    else $error("strap load late");
  a_strap_value: assert property ($rose(strapLoaded) |->
    external_reference_select == strapExtRef && ramp_injection_enable == strapRampInj)
    else $error("strap value not loaded");
  a_delay_write: assert property (wrTo(8'hD1) |=>
    power_on_delay_code == 3'($past(regWrData))) else $error("delay code write");
  a_delay_decode: assert property (!$past(rst) |->
    powerOnDelayCycles == 20'(DELAY_BASE_CYCLES << $past(power_on_delay_code)))
    else $error("delay decode");
  a_loop_write: assert property (wrTo(8'hD3) |=>
    {ramp_injection_enable, 4'h0, switching_frequency_code} == ($past(regWrData) & 8'h87))
    else $error("loop register write");
  a_freq_decode: assert property (!$past(rst) |->
    switchingFrequencyKhz == KHZ[$past(switching_frequency_code)]) else $error("khz");
  a_ref_write: assert property (wrTo(8'hD2) |=>
    {external_reference_select, 7'h00} == ($past(regWrData) & 8'h80)) else $error("ref");
  a_rd_unmapped: assert property (regRdEn && (regAddr < 8'hD1 || regAddr > 8'hD3)
    |=> regRdData == 8'h00) else $error("unmapped read");
  a_rd_idle: assert property (!regRdEn |=> regRdData == 8'h00)
    else $error("read data held");
endmodule : converter_strap_override_sva
bind converter_strap_override_regs converter_strap_override_sva #(
  .DELAY_BASE_CYCLES(DELAY_BASE_CYCLES)) chk (.*);

// ---- tb/converter_host_model.sv ----
// Purpose: management bus host on the command-code strobe port
// Assumes: one request at a time
// Notes: tasks are called by hierarchical name
`timescale 1ns/1ps
module converter_host_model (
  input wire logic core_clk,
  output logic [7:0] regAddr,
  output logic regWrEn,
  output logic [7:0] regWrData,
  output logic regRdEn,
  input wire logic [7:0] regRdData
);
  initial begin
    regAddr = 8'h00;
    regWrEn = 1'b0;
    regWrData = 8'h00;
    regRdEn = 1'b0;
  end
  // strobe held through the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge core_clk);
    regWrEn <= 1'b0;
  endtask : wr
  // data captured once the taking edge has settled
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge core_clk);
    regRdEn <= 1'b0;
    #1 d = regRdData;
  endtask : rd
endmodule : converter_host_model

// ---- tb/tb_converter_strap_override_regs.sv ----
// Purpose: directed register tests for the strap override block
// Assumes: straps static between resets; short base counts
// Notes: bus traffic goes through the host model
`timescale 1ns/1ps
module tb_converter_strap_override_regs;
  logic core_clk, rst = 1'b1, ssActive = 1'b0;
  logic [7:0] regAddr, regWrData, regRdData, rdVal, wd;
  logic regWrEn, regRdEn, strapLoaded, contMode, extRef, extRamp, uvLatch, rampInj;
  logic [1:0] rampScale;
  logic [2:0] freqCode;
  logic [19:0] delayCycles, ssCycles;
  logic [8:0] straps = 9'h15B;
  int mismatches = 0;
  int comparisons = 0;
  converter_strap_override_regs #(.DELAY_BASE_CYCLES(4), .SOFTSTART_BASE_CYCLES(8)) DUT (
    .core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .strapExtRef(straps[8]), .strapExtRamp(straps[7]), .strapSoftstartTime(straps[6:5]),
    .strapUvLatch(straps[4]), .strapCcm(straps[3]), .strapRampInj(straps[2]),
    .strapRampScale(straps[1:0]), .softstartActive(ssActive), .strapLoaded(strapLoaded),
    .power_on_delay_code(), .powerOnDelayCycles(delayCycles),
    .external_reference_select(extRef), .external_ramp_select(extRamp),
    .softstartCycles(ssCycles), .undervoltage_latch_select(uvLatch),
    .forced_continuous_conduction(contMode), .ramp_injection_enable(rampInj),
    .ramp_resistor_scale(rampScale), .switching_frequency_code(freqCode),
    .switchingFrequencyKhz());
  converter_host_model host (.core_clk(core_clk), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData));
  // 10 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic chk(input string n, input logic [19:0] e, input logic [19:0] g);
    comparisons++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      mismatches++;
    end
  endtask : chk
  task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, rdVal);
    chk($sformatf("reg %h", a), 20'(e), 20'(rdVal));
  endtask : rdChk
  // power-on reset with given straps, then readback of all three registers
  task automatic boot(input logic [8:0] s, input logic [7:0] e2, input logic [7:0] e3);
    @(posedge core_clk);
    rst <= 1'b1;
    straps <= s;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    for (int k = 0; k < 8 && strapLoaded !== 1'b1; k++) tick(1);
    chk("loaded", 1, strapLoaded);
    rdChk(8'hD2, e2);
    rdChk(8'hD3, e3);
    rdChk(8'hD1, 8'h02);
  endtask : boot
  task automatic stop_test();
    if (mismatches == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test
  // main sequence
  initial begin
    boot(9'h15B, 8'h9B, 8'h33);
    chk("ss time", 32, ssCycles);
    chk("delay", 16, delayCycles);
    chk("ref", 1, extRef);
    @(posedge core_clk) ssActive <= 1'b1;
    tick(3);
    chk("contMode", 0, contMode);
    @(posedge core_clk) ssActive <= 1'b0;
    tick(3);
    chk("contMode", 1, contMode);
    host.wr(8'hD2, 8'hE3);
    @(posedge core_clk) ssActive <= 1'b1;
    rdChk(8'hD2, 8'hC3);
    chk("contMode", 1, contMode);
    chk("ramp", 1, extRamp);
    for (int i = 0; i < 4; i++) begin
      wd = 8'(i * 4 + (i % 2) * 2);
      host.wr(8'hD2, wd);
      rdChk(8'hD2, wd);
      chk("ss time", 8 << i, ssCycles);
      chk("uv", i % 2, uvLatch);
      chk("contMode", 0, contMode);
    end
    for (int i = 0; i < 8; i++) begin
      wd = 8'(8'h48 | (i % 2) * 128 | (i % 4) * 16 | i);
      host.wr(8'hD3, wd);
      rdChk(8'hD3, wd & 8'hB7);
      chk("scale", i % 4, rampScale);
      chk("inj", i % 2, rampInj);
      host.wr(8'hD1, 8'(8'hF8 | i));
      rdChk(8'hD1, 8'(i));
      chk("delay", 4 << i, delayCycles);
    end
    host.wr(8'hD0, 8'hFF);
    rdChk(8'hD0, 8'h00);
    rdChk(8'hD4, 8'h00);
    boot(9'h0A4, 8'h54, 8'h83);
    chk("freq", 3, freqCode);
    stop_test();
  end
  // hang guard
  initial begin
    #400_000;
    mismatches++;
    stop_test();
  end
endmodule : tb_converter_strap_override_regs
